// ===== src/emmd_decoder.sv
// Purpose: steers each emulated access to one target, places the monitor bank,
//          and clears selected flash blocks at download
// Assumes: access address and strobe come from logic on this clock
// Notes: target and status outputs are registered, one cycle after the access
`timescale 1ns/100ps
`default_nettype none
module emmd_decoder
	import emmd_pkg::*;
#(
	parameter logic [ADDR_W-1:0] SFR_END      = 24'h000400,
	parameter logic [ADDR_W-1:0] RAM_END      = 24'h008000,
	parameter logic [ADDR_W-1:0] ROM_BASE     = 24'hf00000,
	parameter logic [ADDR_W-1:0] VEC_BASE     = 24'hffffdc,
	parameter logic [ADDR_W-1:0] RSV_BASE     = 24'h008000,
	parameter logic [ADDR_W-1:0] RSV_END      = 24'h00f000,
	parameter logic [BANK_W-1:0] MUX_BANK_LO  = 8'h00,
	parameter logic [BANK_W-1:0] MUX_BANK_HI  = 8'h00,
	parameter int                FBLK_BANKS_W = 4
)(
	input  wire logic                      clock,
	input  wire logic                      rst_n,
	input  wire logic [1:0]                proc_mode,
	input  wire logic [NUM_AREAS*BANK_W-1:0] area_base,
	input  wire logic [NUM_AREAS-1:0]      area_len,
	input  wire logic [NUM_AREAS*2-1:0]    area_map,
	input  wire logic [BANK_W-1:0]         mon_bank,
	input  wire logic                      acc_valid,
	input  wire logic [ADDR_W-1:0]         acc_addr,
	input  wire logic [FLASH_BLOCKS-1:0]   flash_keep,
	input  wire logic                      dl_start,
	output logic [3:0]                     acc_target,
	output logic                           acc_done,
	output logic                           mon_reject,
	output logic                           cfg_error,
	output logic                           erase_busy,
	output logic                           erase_done,
	output logic                           erase_stb,
	output logic [$clog2(FLASH_BLOCKS)-1:0] erase_block,
	output logic [7:0]                     erase_value
);
	// refuse flash block settings the sequencer cannot step through
	if (FLASH_BLOCKS < 2 || FBLK_BANKS_W < 1) begin : g_bad_param
		$error("emmd_decoder: bad flash block parameters");
	end

	localparam int BI_W = $clog2(FLASH_BLOCKS);
	localparam logic [BI_W-1:0] LAST_BLK = BI_W'(FLASH_BLOCKS - 1);

	////////////////////////////////////////////////////////////////////////////
	// fixed regions
	wire logic [BANK_W-1:0] acc_bank = acc_addr[ADDR_W-1:ADDR_W-BANK_W];
	wire logic areas_on  = (proc_mode == MODE_MEMEXP) || (proc_mode == MODE_MICRO);
	wire logic rom_on    = (proc_mode == MODE_SINGLE) || (proc_mode == MODE_MEMEXP);
	wire logic in_vec    = acc_addr >= VEC_BASE;
	wire logic in_sfrram = acc_addr < RAM_END;
	wire logic in_rom    = rom_on && (acc_addr >= ROM_BASE);
	wire logic in_rsv    = (acc_addr >= RSV_BASE) && (acc_addr < RSV_END);
	// any fixed region, used by the checks below
	wire logic in_fixed  = in_vec || in_sfrram || in_rom || in_rsv;

	// bank check used for the monitor placement
	function automatic logic bank_forbidden(input logic [BANK_W-1:0] b);
		logic [BANK_W-1:0] rom_bank;
		logic [BANK_W-1:0] ram_bank;
		rom_bank = ROM_BASE[ADDR_W-1:ADDR_W-BANK_W];
		ram_bank = RAM_END[ADDR_W-1:ADDR_W-BANK_W];
		bank_forbidden = (b >= rom_bank) || (b <= ram_bank)
			|| ((b >= MUX_BANK_LO) && (b <= MUX_BANK_HI));
	endfunction : bank_forbidden

	////////////////////////////////////////////////////////////////////////////
	// configured areas
	logic [NUM_AREAS-1:0] a_hit;
	logic [NUM_AREAS-1:0] a_int;
	logic [NUM_AREAS-1:0] a_mis;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_AREAS; gi++) begin : g_area
			emmd_area_match u_match (
				.bank      (acc_bank),
				.base      (area_base[gi*BANK_W +: BANK_W]),
				.len       (area_len[gi]),
				.map       (area_map[gi*2 +: 2]),
				.hit       (a_hit[gi]),
				.hit_int   (a_int[gi]),
				.misaligned(a_mis[gi])
			);
		end
	endgenerate

	// total internal length in banks
	logic [7:0] int_banks;
	always_comb begin
		int_banks = 8'h00;
		for (int i = 0; i < NUM_AREAS; i++) begin
			if (area_map[i*2 +: 2] == MAP_INT)
				int_banks = int_banks + ((area_len[i] == LEN_1M)
					? 8'(1 << GRAN_LARGE) : 8'(1 << GRAN_SMALL));
		end
	end
	wire logic [7:0] cap_banks = (proc_mode == MODE_MEMEXP) ? 8'(CAP_EXP_BANKS)
		: 8'(CAP_FULL_BANKS);
	wire logic over_cap = areas_on && (int_banks > cap_banks);
	// overlapping hits flag a host mistake
	wire logic overlap  = areas_on && acc_valid && ($countones(a_hit) > 1);
	wire logic cfg_bad  = over_cap || overlap || (|a_mis);

	////////////////////////////////////////////////////////////////////////////
	// target selection, fixed first, then monitor, then areas, then external
	wire logic mon_bad   = bank_forbidden(mon_bank);
	wire logic in_mon    = !mon_bad && (acc_bank == mon_bank);
	wire logic area_int  = areas_on && (|a_int);
	wire logic [3:0] tgt_nxt =
		in_vec    ? TGT_EMEM :
		in_sfrram ? TGT_MCU  :
		in_rom    ? TGT_MCU  :
		in_rsv    ? TGT_MCU  :
		in_mon    ? TGT_MON  :
		area_int  ? TGT_EMEM :
		TGT_EXT;

	// register the decode result
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			acc_target <= TGT_EXT;
			acc_done   <= 1'b0;
			mon_reject <= 1'b0;
			cfg_error  <= 1'b0;
		end else begin
			acc_done   <= acc_valid;
			mon_reject <= mon_bad;
			cfg_error  <= cfg_bad;
			if (acc_valid)
				acc_target <= tgt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// flash erase sequencer, one block per cycle
	emmd_state_t      st_r;
	emmd_state_t      st_nxt;
	logic [BI_W-1:0]  blk_r;
	wire logic        last = blk_r == LAST_BLK;
	wire logic        do_erase = (st_r == EMMD_ERASE) && !flash_keep[blk_r];

	// next state: one pass through the blocks, then a done cycle
	always_comb begin
		case (st_r)
			EMMD_IDLE:  st_nxt = dl_start ? EMMD_ERASE : EMMD_IDLE;
			EMMD_ERASE: st_nxt = last ? EMMD_DONE : EMMD_ERASE;
			EMMD_DONE:  st_nxt = EMMD_IDLE;
			default:    st_nxt = EMMD_IDLE;
		endcase
	end

	// sequencer registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_r        <= EMMD_IDLE;
			blk_r       <= '0;
			erase_busy  <= 1'b0;
			erase_done  <= 1'b0;
			erase_stb   <= 1'b0;
			erase_block <= '0;
			erase_value <= ERASED_BYTE;
		end else begin
			st_r        <= st_nxt;
			blk_r       <= (st_r == EMMD_ERASE && !last) ? blk_r + 1'b1 : '0;
			erase_busy  <= st_nxt == EMMD_ERASE;
			erase_done  <= st_nxt == EMMD_DONE;
			erase_stb   <= do_erase;
			erase_block <= blk_r;
			erase_value <= ERASED_BYTE;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	// fixed regions override every area setting
	vector_emem_a: assert property (@(posedge clock) disable iff (!rst_n)
		acc_valid && acc_addr >= VEC_BASE |=> acc_target == TGT_EMEM)
		else $error("vector access not to emulator memory");

	sfr_mcu_a: assert property (@(posedge clock) disable iff (!rst_n)
		acc_valid && acc_addr < RAM_END |=> acc_target == TGT_MCU)
		else $error("sfr/ram access not to mcu");

	rom_flash_a: assert property (@(posedge clock) disable iff (!rst_n)
		acc_valid && rom_on && acc_addr >= ROM_BASE |=> acc_target == TGT_MCU)
		else $error("rom access not to flash");

	rsv_mcu_a: assert property (@(posedge clock) disable iff (!rst_n)
		acc_valid && in_rsv && !in_vec |=> acc_target == TGT_MCU)
		else $error("reserved access not to mcu");

	// areas stay off in single-chip mode
	single_no_area_a: assert property (@(posedge clock) disable iff (!rst_n)
		acc_valid && proc_mode == MODE_SINGLE |=> acc_target != TGT_EMEM
			|| $past(acc_addr) >= VEC_BASE)
		else $error("area used in single-chip mode");

	// exactly one target per access, done one cycle later
	one_target_a: assert property (@(posedge clock) disable iff (!rst_n)
		acc_done |-> $onehot(acc_target))
		else $error("target not one-hot");

	done_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
		acc_done == $past(acc_valid))
		else $error("access done not one cycle after strobe");

	// addresses outside every region go to the user system
	default_ext_a: assert property (@(posedge clock) disable iff (!rst_n)
		acc_valid && !in_vec && !in_sfrram && !in_rom && !in_rsv && !in_mon
			&& !(areas_on && |a_hit) |=> acc_target == TGT_EXT)
		else $error("unmapped access not external");

	// area mapping choices
	area_int_a: assert property (@(posedge clock) disable iff (!rst_n)
		acc_valid && area_int && !in_vec && !in_sfrram && !in_rom && !in_rsv
			&& !in_mon |=> acc_target == TGT_EMEM)
		else $error("internal area not to emulation memory");

	area_ext_a: assert property (@(posedge clock) disable iff (!rst_n)
		acc_valid && areas_on && (|(a_hit & ~a_int)) && !(|a_int) && !in_fixed
			&& !in_mon |=> acc_target == TGT_EXT)
		else $error("external or unused area not to user system");

	// host mistakes show on the error flag
	misalign_err_a: assert property (@(posedge clock) disable iff (!rst_n)
		(|a_mis) |=> cfg_error)
		else $error("misaligned area base not flagged");

	cap_err_a: assert property (@(posedge clock) disable iff (!rst_n)
		over_cap |=> cfg_error)
		else $error("capacity overrun not flagged");

	// a forbidden monitor bank is flagged and never hit
	mon_reject_a: assert property (@(posedge clock) disable iff (!rst_n)
		mon_bad && $stable(mon_bank) |=> mon_reject)
		else $error("forbidden monitor bank accepted");

	mon_never_a: assert property (@(posedge clock) disable iff (!rst_n)
		acc_valid && mon_bad |=> acc_target != TGT_MON)
		else $error("forbidden monitor bank was hit");

	mon_hit_a: assert property (@(posedge clock) disable iff (!rst_n)
		acc_valid && in_mon && !in_fixed |=> acc_target == TGT_MON)
		else $error("monitor bank access not to monitor");

	// erase pass: eight busy cycles, then done, strobes only for unkept blocks
	keep_block_a: assert property (@(posedge clock) disable iff (!rst_n)
		st_r == EMMD_ERASE && flash_keep[blk_r] |=> !erase_stb)
		else $error("preserved block erased");

	stb_block_a: assert property (@(posedge clock) disable iff (!rst_n)
		erase_stb |-> !flash_keep[erase_block])
		else $error("strobe names a preserved block");

	erase_seq_a: assert property (@(posedge clock) disable iff (!rst_n)
		st_r == EMMD_IDLE && dl_start |=> erase_busy ##[1:16] erase_done)
		else $error("erase sequence did not finish");

	busy_len_a: assert property (@(posedge clock) disable iff (!rst_n)
		st_r == EMMD_IDLE && dl_start |=> erase_busy [*8] ##1 (!erase_busy && erase_done))
		else $error("erase pass length wrong");

	stb_window_a: assert property (@(posedge clock) disable iff (!rst_n)
		erase_stb |-> erase_busy || erase_done)
		else $error("erase strobe outside a pass");

	erase_val_a: assert property (@(posedge clock) disable iff (!rst_n)
		erase_stb |-> erase_value == ERASED_BYTE)
		else $error("erase value wrong");

	// main scenarios
	cov_area_c:  cover property (@(posedge clock) acc_done && acc_target == TGT_EMEM);
	cov_ext_c:   cover property (@(posedge clock) acc_done && acc_target == TGT_EXT);
	cov_mon_c:   cover property (@(posedge clock) acc_done && acc_target == TGT_MON);
	cov_mcu_c:   cover property (@(posedge clock) acc_done && acc_target == TGT_MCU);
	cov_erase_c: cover property (@(posedge clock) erase_done);
endmodule : emmd_decoder
`default_nettype wire

// ===== src/emmd_pkg.sv
// Purpose: shared constants for the emulation memory map decoder
// Assumes: 24-bit access addresses, 8-bit bank numbers
// Notes: fixed-region bounds are defaults; the top module takes them as parameters
package emmd_pkg;
	localparam int ADDR_W       = 24;
	localparam int BANK_W       = 8;
	localparam int NUM_AREAS    = 4;
	localparam int FLASH_BLOCKS = 8;
	// bank bits ignored per length
	localparam int GRAN_SMALL   = 2;   // 256 KB, 4 banks
	localparam int GRAN_LARGE   = 4;   // 1 MB, 16 banks
	// emulation memory capacity in banks of 64 KB
	localparam int CAP_FULL_BANKS = 64;  // 4 MB
	localparam int CAP_EXP_BANKS  = 48;  // 3.00 MB
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	// area length codes
	localparam logic LEN_256K = 1'b0;
	localparam logic LEN_1M   = 1'b1;

	// area mapping codes
	localparam logic [1:0] MAP_NONE = 2'h0;
	localparam logic [1:0] MAP_INT  = 2'h1;
	localparam logic [1:0] MAP_EXT  = 2'h2;

	// processor modes
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_MEMEXP = 2'h1;
	localparam logic [1:0] MODE_MICRO  = 2'h2;

	// targets, one-hot
	localparam logic [3:0] TGT_EMEM = 4'h1;
	localparam logic [3:0] TGT_MCU  = 4'h2;
	localparam logic [3:0] TGT_EXT  = 4'h4;
	localparam logic [3:0] TGT_MON  = 4'h8;

	// erase sequencer states
	typedef enum logic [2:0] {
		EMMD_IDLE  = 3'b001,
		EMMD_ERASE = 3'b010,
		EMMD_DONE  = 3'b100
	} emmd_state_t;
endpackage : emmd_pkg

// ===== src/emmd_area_match.sv
// Purpose: tests one configured area against an access bank
// Assumes: bank values aligned by the configuring party
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
module emmd_area_match
	import emmd_pkg::*;
(
	input  wire logic [BANK_W-1:0] bank,
	input  wire logic [BANK_W-1:0] base,
	input  wire logic              len,
	input  wire logic [1:0]        map,
	output logic                   hit,
	output logic                   hit_int,
	output logic                   misaligned
);
	// compare only the bank bits above the granularity
	wire logic hit_small = bank[BANK_W-1:GRAN_SMALL] == base[BANK_W-1:GRAN_SMALL];
	wire logic hit_large = bank[BANK_W-1:GRAN_LARGE] == base[BANK_W-1:GRAN_LARGE];
	wire logic mis_small = |base[GRAN_SMALL-1:0];
	wire logic mis_large = |base[GRAN_LARGE-1:0];

	assign hit        = (len == LEN_1M) ? hit_large : hit_small;
	assign hit_int    = hit && (map == MAP_INT);
	assign misaligned = (len == LEN_1M) ? mis_large : mis_small;
endmodule : emmd_area_match
`default_nettype wire

// ===== verification/emmd_flash_model.sv
// Purpose: internal flash model answering the erase strobes
// Assumes: one byte stands for the contents of each block
// Notes: each block starts with its own marker value
`timescale 1ns/100ps
`default_nettype none
module emmd_flash_model
	import emmd_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       erase_stb,
	input  wire logic [2:0] erase_block,
	input  wire logic [7:0] erase_value,
	output var  logic [63:0] flash_mem
);
	// preload distinct contents
	initial begin
		for (int k = 0; k < FLASH_BLOCKS; k++)
			flash_mem[k*8 +: 8] = 8'h30 + k;
	end
	// one block overwritten per strobe, the rest untouched
	always @(posedge clock) begin
		if (erase_stb === 1'b1) begin
			flash_mem[erase_block*8 +: 8] <= erase_value;
		end
	end
endmodule : emmd_flash_model
`default_nettype wire

// ===== verification/test_emmd_decoder.sv
// Purpose: self-checking bench for the memory map decoder
// Assumes: default fixed-region parameters
// Notes: inputs change at the falling edge
`timescale 1ns/100ps
`default_nettype none
module test_emmd_decoder;
	import emmd_pkg::*;
	logic        clock = 0;
	logic        rst_n = 0;
	logic [1:0]  proc_mode = MODE_MICRO;
	logic [31:0] area_base = '0;
	logic [3:0]  area_len = '0;
	logic [7:0]  area_map = '0;
	logic [7:0]  mon_bank = 8'hd0;
	logic        acc_valid = 0;
	logic [23:0] acc_addr = '0;
	logic [7:0]  flash_keep = 8'h5a;
	logic        dl_start = 0;
	logic [3:0]  acc_target;
	logic        acc_done, mon_reject, cfg_error, erase_busy, erase_done, erase_stb;
	logic [2:0]  erase_block;
	logic [7:0]  erase_value;
	logic [63:0] flash_mem;
	int          failures = 0;
	int          n_checks = 0;
	int          i, n;
	//////////////////////////////////////////////////
	emmd_decoder i_emmd_decoder (.clock, .rst_n, .proc_mode, .area_base, .area_len,
		.area_map, .mon_bank, .acc_valid, .acc_addr, .flash_keep, .dl_start, .acc_target,
		.acc_done, .mon_reject, .cfg_error, .erase_busy, .erase_done, .erase_stb,
		.erase_block, .erase_value);
	emmd_flash_model i_emmd_flash_model (.clock, .erase_stb, .erase_block, .erase_value,
		.flash_mem);
	initial forever #2.5 clock = ~clock;
	//////////////////////////////////////////////////
	task automatic chk_tgt(input logic [3:0] g, input logic [3:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: target got %h expected %h", $time, g, e);
		end
	endtask : chk_tgt
	task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: value got %h expected %h", $time, g, e);
		end
	endtask : chk_val
	task automatic set_area(input int k, input logic [7:0] b, input logic l,
		input logic [1:0] m);
		area_base[k*8 +: 8] = b;
		area_len[k] = l;
		area_map[k*2 +: 2] = m;
	endtask : set_area
	// one strobed access, bounded wait for done, then target check
	task automatic access(input logic [23:0] a, input logic [3:0] e);
		@(negedge clock);
		acc_valid = 1;
		acc_addr = a;
		@(negedge clock);
		acc_valid = 0;
		chk_val(acc_done, 8'h01);
		n = 0;
		while (acc_done !== 1'b1 && n < 4) begin
			@(negedge clock);
			n++;
		end
		chk_tgt(acc_target, e);
	endtask : access
	task automatic settle_chk(input logic g_sel, input logic [7:0] e);
		repeat (2) @(negedge clock);
		chk_val(g_sel ? mon_reject : cfg_error, e);
	endtask : settle_chk
	task automatic report_and_stop();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	//////////////////////////////////////////////////
	initial begin
		#5000;
		failures++;
		report_and_stop();
	end
	initial begin
		repeat (6) @(negedge clock);
		rst_n = 1;
		chk_tgt(acc_target, TGT_EXT);
		chk_val(erase_value, ERASED_BYTE);
		// aligned, disjoint, 2.5 MB in total
		set_area(0, 8'h10, LEN_256K, MAP_INT);
		set_area(1, 8'h20, LEN_1M, MAP_INT);
		set_area(2, 8'h40, LEN_256K, MAP_NONE);
		set_area(3, 8'h80, LEN_1M, 2'h3);
		access(24'h130000, TGT_EMEM);
		access(24'h140000, TGT_EXT);
		access(24'h0fffff, TGT_EXT);
		access(24'h2fffff, TGT_EMEM);
		access(24'h300000, TGT_EXT);
		access(24'h43ffff, TGT_EXT);
		access(24'h8abcde, TGT_EXT);
		access(24'h000100, TGT_MCU);
		access(24'h007fff, TGT_MCU);
		access(24'hffffe0, TGT_EMEM);
		access(24'hd01234, TGT_MON);
		access(24'hf10000, TGT_EXT);
		chk_val(cfg_error, 8'h00);
		proc_mode = MODE_SINGLE;
		access(24'h130000, TGT_EXT);
		access(24'hf10000, TGT_MCU);
		proc_mode = MODE_MEMEXP;
		access(24'h130000, TGT_EMEM);
		access(24'hf10000, TGT_MCU);
		$display("test map done");
		// forbidden monitor banks, then a legal one
		for (i = 0; i < 3; i++) begin
			mon_bank = (i == 2) ? 8'hd0 : ((i == 1) ? 8'h00 : 8'hf0);
			settle_chk(1'b1, i < 2);
			if (i == 1) access(24'h00f800, TGT_EXT);
		end
		$display("test monitor done");
		// misaligned bases and capacity overrun
		set_area(0, 8'h12, LEN_256K, MAP_INT);
		settle_chk(1'b0, 8'h01);
		set_area(0, 8'h10, LEN_256K, MAP_INT);
		set_area(1, 8'h28, LEN_1M, MAP_INT);
		settle_chk(1'b0, 8'h01);
		set_area(1, 8'h20, LEN_1M, MAP_INT);
		set_area(2, 8'h40, LEN_1M, MAP_INT);
		set_area(3, 8'h80, LEN_1M, MAP_INT); // 3.25 MB internal
		settle_chk(1'b0, 8'h01);
		proc_mode = MODE_MICRO;
		settle_chk(1'b0, 8'h00);
		$display("test config done");
		// erase pass with half the blocks kept
		dl_start = 1;
		@(negedge clock);
		dl_start = 0;
		n = 0;
		i = 0;
		while (erase_done !== 1'b1 && i < 20) begin
			if (erase_busy === 1'b1) n++;
			@(negedge clock);
			i++;
		end
		chk_val(8'(n), 8'h08);
		chk_val(erase_done, 8'h01);
		@(negedge clock);
		for (i = 0; i < 8; i++)
			chk_val(flash_mem[i*8 +: 8], flash_keep[i] ? 8'h30 + i : ERASED_BYTE);
		$display("test erase done");
		report_and_stop();
	end
endmodule : test_emmd_decoder
`default_nettype wire
